// file: verilog/mscyt_pkg.sv
// Constants shared by the multi-stage cycle timer and its tick divider.
// Assumes a 125 MHz core clock; times are held in tenths of a second.
package mscyt_pkg;
    localparam int          STAGE_MAX      = 8;
    localparam int          STAGE_W        = 3;
    localparam int          PASS_W         = 32;
    localparam int          TIME_W         = 15;       // Tenths of a second, up to 30000
    localparam int          CLK_HZ         = 125000000;
    localparam int          TICK_S_DIV     = 10;       // One time unit is 0.1 s
    localparam int          TICK_CYCLES    = CLK_HZ / TICK_S_DIV;
    localparam int          PRE_W          = 24;
    localparam logic [3:0]  STAGES_MIN     = 4'h2;
    localparam logic [3:0]  STAGES_RESET   = 4'h8;
    localparam logic [15:0] PASSES_RESET   = 16'h0000;
    localparam logic [TIME_W-1:0] ON_MIN   = 15'h0001; // 0.1 s
    localparam logic [TIME_W-1:0] ON_MAX   = 15'h7530; // 3000.0 s
    localparam logic [TIME_W-1:0] ON_RESET = 15'h000a; // 1.0 s
    localparam logic [TIME_W-1:0] OFF_RESET = 15'h0000;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STAGES    = 8'h04;
    localparam logic [7:0]  ADDR_PASSES    = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
    localparam logic [7:0]  ADDR_PASSCNT   = 8'h10;
    localparam logic [7:0]  ADDR_ON_BASE   = 8'h20;
    localparam logic [7:0]  ADDR_OFF_BASE  = 8'h40;
    localparam int          CTRL_START     = 0;
    localparam int          CTRL_RESUME    = 1;
    localparam int          CTRL_HOLD      = 2;
    typedef enum logic [1:0] {MSCYT_IDLE, MSCYT_ON, MSCYT_OFF, MSCYT_DONE} mscyt_state_t;
endpackage

// file: verilog/mscyt_tick.sv
// Free-running divider making a one-cycle pulse every 0.1 s.
// Assumes core_clk at the package rate; no external inputs.
`timescale 1ns/10ps
module mscyt_tick
    import mscyt_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES // Cycles per time unit; lowered only to keep simulations short
)
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // Tick pulse
    output logic      tick
);
    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_next;
    logic             tick_next;

    // Wrap the prescaler at the end of each tenth of a second
    always_comb
    begin
        tick_next = (pre_reg == PRE_W'(TICK_DIV - 1));
        pre_next  = tick_next ? '0 : pre_reg + 1'b1;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pre_reg <= '0;
            tick    <= 1'b0;
        end
        else
        begin
            pre_reg <= pre_next;
            tick    <= tick_next;
        end
    end
endmodule

// file: verilog/mscyt_timer.sv
// Multi-stage cycle timer: sequences on/off periods per stage for passes.
// Assumes a register master on core_clk; run and stage feed other logic.
`timescale 1ns/10ps
module mscyt_timer
    import mscyt_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES // Cycles per 0.1 s; a bench may lower it to reach stage changes
)
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    // Sequencer outputs
    output logic                       run,
    output logic      [STAGE_W-1:0]    stage,
    output logic      [PASS_W-1:0]     pass_count
);
    import mscyt_pkg::*;

    // Configuration registers
    logic [2:0]        ctrl_reg, ctrl_next;
    logic [3:0]        stages_reg, stages_next;
    logic [15:0]       passes_reg, passes_next;
    logic [TIME_W-1:0] on_reg  [STAGE_MAX];
    logic [TIME_W-1:0] off_reg [STAGE_MAX];
    logic [TIME_W-1:0] on_next  [STAGE_MAX];
    logic [TIME_W-1:0] off_next [STAGE_MAX];
    logic [31:0]       rdata_next;
    // Sequencer state
    mscyt_state_t      state_reg, state_next;
    logic [STAGE_W-1:0] stage_reg, stage_next;
    logic [PASS_W-1:0] pass_reg, pass_next;
    logic [TIME_W-1:0] left_reg, left_next;
    logic              run_next;
    logic              start_d_reg;
    logic              tick;

    // Indexed decode of a per-stage window; used for on and off tables
    function automatic logic in_table(input logic [7:0] a, input logic [7:0] base);
        in_table = (a >= base) && (a < base + 8'h20) && (a[1:0] == 2'b00);
    endfunction

    mscyt_tick #(.TICK_DIV(TICK_DIV)) u_tick
    (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tick     (tick)
    );

    // Register writes; out-of-range values are clamped so timing stays legal
    always_comb
    begin
        ctrl_next   = ctrl_reg;
        stages_next = stages_reg;
        passes_next = passes_reg;
        for (int i = 0; i < STAGE_MAX; i++)
        begin
            on_next[i]  = on_reg[i];
            off_next[i] = off_reg[i];
        end
        if (reg_wr)
        begin
            if (reg_addr == ADDR_CTRL)
            begin
                ctrl_next = reg_wdata[2:0];
            end
            else if (reg_addr == ADDR_STAGES)
            begin
                if (reg_wdata[3:0] < STAGES_MIN)
                    stages_next = STAGES_MIN;
                else if (reg_wdata[31:4] != '0 || reg_wdata[3:0] > STAGES_RESET)
                    stages_next = STAGES_RESET;
                else
                    stages_next = reg_wdata[3:0];
            end
            else if (reg_addr == ADDR_PASSES)
            begin
                passes_next = reg_wdata[15:0];
            end
            else if (in_table(reg_addr, ADDR_ON_BASE))
            begin
                if (reg_wdata[TIME_W-1:0] < ON_MIN)
                    on_next[reg_addr[4:2]] = ON_MIN;
                else if (reg_wdata[31:TIME_W] != '0 || reg_wdata[TIME_W-1:0] > ON_MAX)
                    on_next[reg_addr[4:2]] = ON_MAX;
                else
                    on_next[reg_addr[4:2]] = reg_wdata[TIME_W-1:0];
            end
            else if (in_table(reg_addr, ADDR_OFF_BASE))
            begin
                if (reg_wdata[31:TIME_W] != '0 || reg_wdata[TIME_W-1:0] > ON_MAX)
                    off_next[reg_addr[4:2]] = ON_MAX;
                else
                    off_next[reg_addr[4:2]] = reg_wdata[TIME_W-1:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = '0;
        if (reg_rd)
        begin
            if (reg_addr == ADDR_CTRL)
                rdata_next = {29'h0, ctrl_reg};
            else if (reg_addr == ADDR_STAGES)
                rdata_next = {28'h0, stages_reg};
            else if (reg_addr == ADDR_PASSES)
                rdata_next = {16'h0, passes_reg};
            else if (reg_addr == ADDR_STATUS)
                rdata_next = {24'h0, 1'b0, stage_reg, (state_reg == MSCYT_DONE),
                              (state_reg != MSCYT_IDLE), run, 1'b0};
            else if (reg_addr == ADDR_PASSCNT)
                rdata_next = pass_reg;
            else if (in_table(reg_addr, ADDR_ON_BASE))
                rdata_next = {17'h0, on_reg[reg_addr[4:2]]};
            else if (in_table(reg_addr, ADDR_OFF_BASE))
                rdata_next = {17'h0, off_reg[reg_addr[4:2]]};
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg   <= '0;
            stages_reg <= STAGES_RESET;
            passes_reg <= PASSES_RESET;
            reg_rdata  <= '0;
            for (int i = 0; i < STAGE_MAX; i++)
            begin
                on_reg[i]  <= ON_RESET;
                off_reg[i] <= OFF_RESET;
            end
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            stages_reg <= stages_next;
            passes_reg <= passes_next;
            reg_rdata  <= rdata_next;
            for (int i = 0; i < STAGE_MAX; i++)
            begin
                on_reg[i]  <= on_next[i];
                off_reg[i] <= off_next[i];
            end
        end
    end

    // Sequencer: start edge enters the on period, ticks count time down.
    // A zero off time costs one tick, keeping each stage change visible.
    always_comb
    begin
        state_next = state_reg;
        stage_next = stage_reg;
        pass_next  = pass_reg;
        left_next  = left_reg;
        if (!ctrl_reg[CTRL_START])
        begin
            state_next = MSCYT_IDLE;
        end
        else if (!start_d_reg)
        begin
            state_next = MSCYT_ON;
            if (!ctrl_reg[CTRL_RESUME] || {1'b0, stage_reg} >= stages_reg)
            begin
                stage_next = '0;
                pass_next  = '0;
            end
            left_next  = on_reg[stage_next];
        end
        else if (tick)
        begin
            case (state_reg)
                MSCYT_ON:
                begin
                    if (left_reg <= 15'h0001)
                    begin
                        state_next = MSCYT_OFF;
                        left_next  = off_reg[stage_reg];
                    end
                    else
                        left_next = left_reg - 1'b1;
                end
                MSCYT_OFF:
                begin
                    if (left_reg <= 15'h0001)
                    begin
                        // A count shrunk below the active stage wraps here, never past stage 7
                        if ({1'b0, stage_reg} >= stages_reg - 4'h1)
                        begin
                            pass_next = pass_reg + 1'b1;
                            if (passes_reg != '0 && pass_next >= PASS_W'(passes_reg))
                                state_next = MSCYT_DONE;
                            else
                            begin
                                stage_next = '0;
                                state_next = MSCYT_ON;
                            end
                        end
                        else
                        begin
                            stage_next = stage_reg + 1'b1;
                            state_next = MSCYT_ON;
                        end
                        left_next = on_reg[stage_next];
                    end
                    else
                        left_next = left_reg - 1'b1;
                end
                default:
                begin
                    state_next = state_reg;
                end
            endcase
        end
        // Run only during on time, or held at the last stage when finished
        run_next = (state_next == MSCYT_ON) ||
                   (state_next == MSCYT_DONE && ctrl_reg[CTRL_HOLD]);
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg   <= MSCYT_IDLE;
            stage_reg   <= '0;
            pass_reg    <= '0;
            left_reg    <= '0;
            start_d_reg <= 1'b0;
            run         <= 1'b0;
            stage       <= '0;
            pass_count  <= '0;
        end
        else
        begin
            state_reg   <= state_next;
            stage_reg   <= stage_next;
            pass_reg    <= pass_next;
            left_reg    <= left_next;
            start_d_reg <= ctrl_reg[CTRL_START];
            run         <= run_next;
            stage       <= stage_next;
            pass_count  <= pass_next;
        end
    end

    // Checks
    // Run is made from the control bits of the cycle before, so hold is looked at there
    property p_run_only_on;
        @(posedge core_clk) disable iff (!rstn)
        run |-> (state_reg == MSCYT_ON || (state_reg == MSCYT_DONE && $past(ctrl_reg[CTRL_HOLD])));
    endproperty
    a_run_only_on: assert property (p_run_only_on) else $error("run outside on time");
    property p_start_first;
        @(posedge core_clk) disable iff (!rstn)
        (ctrl_reg[CTRL_START] && !start_d_reg && !ctrl_reg[CTRL_RESUME])
            |=> (state_reg == MSCYT_ON && stage_reg == 3'h0 && pass_reg == '0 && run);
    endproperty
    a_start_first: assert property (p_start_first) else $error("start did not begin at stage zero");
    property p_stop_drops;
        @(posedge core_clk) disable iff (!rstn) !ctrl_reg[CTRL_START] |=> !run;
    endproperty
    a_stop_drops: assert property (p_stop_drops) else $error("run not dropped on stop");
    property p_stage_ascend;
        @(posedge core_clk) disable iff (!rstn)
        (start_d_reg && ctrl_reg[CTRL_START] && stage_reg != $past(stage_reg))
            |-> (stage_reg == $past(stage_reg) + 3'h1 || stage_reg == 3'h0);
    endproperty
    a_stage_ascend: assert property (p_stage_ascend) else $error("stage skipped");
    property p_stage_range;
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == MSCYT_ON && $past(state_reg) != MSCYT_ON) |-> {1'b0, stage_reg} < $past(stages_reg);
    endproperty
    a_stage_range: assert property (p_stage_range) else $error("stage beyond count");
    property p_no_hold;
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == MSCYT_DONE && !$past(ctrl_reg[CTRL_HOLD])) |-> !run;
    endproperty
    a_no_hold: assert property (p_no_hold) else $error("run kept without hold");
    property p_hold;
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == MSCYT_DONE && $past(ctrl_reg[CTRL_HOLD]) && $past(ctrl_reg[CTRL_START])) |-> run;
    endproperty
    a_hold: assert property (p_hold) else $error("hold did not keep run");
    property p_pass_step;
        @(posedge core_clk) disable iff (!rstn)
        (pass_reg != $past(pass_reg) && $past(start_d_reg)) |-> (pass_reg == $past(pass_reg) + 1);
    endproperty
    a_pass_step: assert property (p_pass_step) else $error("pass count jumped");
    property p_limit;
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == MSCYT_DONE && $past(state_reg) != MSCYT_DONE) |-> $past(passes_reg) != '0;
    endproperty
    a_limit: assert property (p_limit) else $error("finished with endless passes");
    property p_on_bounds;
        @(posedge core_clk) disable iff (!rstn) on_reg[0] >= ON_MIN && on_reg[0] <= ON_MAX;
    endproperty
    a_on_bounds: assert property (p_on_bounds) else $error("on time out of range");
    c_done:  cover property (@(posedge core_clk) disable iff (!rstn) state_reg == MSCYT_DONE);
    c_wrap:  cover property (@(posedge core_clk) disable iff (!rstn) pass_reg == 32'h2);
    c_off:   cover property (@(posedge core_clk) disable iff (!rstn) state_reg == MSCYT_OFF);
endmodule

// file: test/mscyt_far_end.sv
// Model of the far side of the timer: a preset speed selector and a forward run request.
// Assumes run and stage come straight from the timer on core_clk.
`timescale 1ns/10ps
module mscyt_far_end
    import mscyt_pkg::*;
#(
    parameter logic [15:0] SPEED_BASE = 16'h0100
)
(
    // Timer outputs seen by the far side
    input  wire logic [STAGE_W-1:0] stage,
    input  wire logic               run,
    // Commands inside the drive
    output logic      [15:0]        preset_speed,
    output logic                    fwd_run_req
);
    // Each stage picks its own preset; a table of SPEED_BASE plus index keeps it checkable
    assign preset_speed = SPEED_BASE + {13'h0000, stage};
    // Forward run follows the run output with no extra latching
    assign fwd_run_req  = run;
endmodule

// file: test/mscyt_timer_tb.sv
// Self-checking bench for the cycle timer, driven over its register port.
// Assumes the timer's time unit is shortened to TICK cycles so stages advance.
`timescale 1ns/10ps
module mscyt_timer_tb;
    import mscyt_pkg::*;
    logic               core_clk;
    logic               rstn;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [31:0]        reg_rdata;
    logic               run;
    logic [STAGE_W-1:0] stage;
    logic [PASS_W-1:0]  pass_count;
    logic [15:0]        preset_speed;
    logic               fwd_run_req;
    logic [31:0]        rv;
    logic               held;
    int                 bad_count;
    int                 checked;
    int                 n;
    localparam int      TICK = 4;       // Cycles per 0.1 s unit in this bench

    mscyt_timer #(.TICK_DIV(TICK)) DUT (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .run        (run),
        .stage      (stage),
        .pass_count (pass_count)
    );

    mscyt_far_end u_far (
        .stage        (stage),
        .run          (run),
        .preset_speed (preset_speed),
        .fwd_run_req  (fwd_run_req)
    );

    // 125 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // One-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample it there
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(what, exp, d);
    endtask

    // Outputs and the far side's view of them, checked at once
    task automatic seq_chk(input logic exp_run, input logic [2:0] exp_stage, input logic [31:0] exp_pass);
        chk("run", {31'h0, exp_run}, {31'h0, run});
        chk("stage", {29'h0, exp_stage}, {29'h0, stage});
        chk("pass count", exp_pass, pass_count);
        chk("far side speed", 32'h0100 + {29'h0, exp_stage}, {16'h0, preset_speed});
        chk("far side run", {31'h0, exp_run}, {31'h0, fwd_run_req});
    endtask

    task automatic out_chk(input logic exp_run);
        seq_chk(exp_run, 3'h0, 32'h0);
    endtask

    // Start write lands at one edge; run follows at the next edge
    task automatic start(input logic [31:0] ctrl);
        wr(ADDR_CTRL, ctrl);
        @(posedge core_clk);
        #1;
    endtask

    // Bounded wait for run (pick 0) or the pass count (pick 1); a timeout is a mismatch
    task automatic wait_for(input logic pick, input string what, input logic [31:0] exp, input int limit,
                            output int cnt);
        logic [31:0] v;
        v = pick ? pass_count : {31'h0, run};
        for (cnt = 0; cnt < limit && v !== exp; cnt++)
        begin
            @(posedge core_clk);
            #1;
            v = pick ? pass_count : {31'h0, run};
        end
        chk(what, exp, v);
    endtask

    // Stop must drop run within three cycles of the write edge
    task automatic stop();
        int k;
        wr(ADDR_CTRL, 32'h0);
        wait_for(1'b0, "run after stop", 32'h0, 3, k);
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        bad_count = 0;
        checked   = 0;
        rstn      = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;

        // Reset values of outputs and registers
        out_chk(1'b0);
        rd_chk("ctrl", ADDR_CTRL, 32'h0);
        rd_chk("stages", ADDR_STAGES, {28'h0, STAGES_RESET});
        rd_chk("passes", ADDR_PASSES, {16'h0, PASSES_RESET});
        rd_chk("status", ADDR_STATUS, 32'h0);
        rd_chk("pass count reg", ADDR_PASSCNT, 32'h0);
        for (int i = 0; i < STAGE_MAX; i++)
        begin
            rd_chk("on time", ADDR_ON_BASE + 8'(4 * i), {17'h0, ON_RESET});
            rd_chk("off time", ADDR_OFF_BASE + 8'(4 * i), {17'h0, OFF_RESET});
        end
        rd_chk("unmapped", 8'h14, 32'h0);
        @(posedge core_clk);
        #1;
        chk("idle read data", 32'h0, reg_rdata);
        $display("test reset done");

        // Range limits of the settings
        wr(ADDR_STAGES, 32'h1);
        rd_chk("stages low", ADDR_STAGES, {28'h0, STAGES_MIN});
        wr(ADDR_STAGES, 32'h9);
        rd_chk("stages high", ADDR_STAGES, 32'h8);
        wr(ADDR_STAGES, 32'h5);
        rd_chk("stages mid", ADDR_STAGES, 32'h5);
        wr(ADDR_ON_BASE + 8'h0c, 32'h0);
        rd_chk("on low", ADDR_ON_BASE + 8'h0c, {17'h0, ON_MIN});
        wr(ADDR_ON_BASE + 8'h0c, 32'h9c40);
        rd_chk("on high", ADDR_ON_BASE + 8'h0c, {17'h0, ON_MAX});
        wr(ADDR_OFF_BASE + 8'h14, 32'h9c40);
        rd_chk("off high", ADDR_OFF_BASE + 8'h14, 32'h7530);
        wr(ADDR_ON_BASE, 32'h64);
        rd_chk("on mid", ADDR_ON_BASE, 32'h64);
        wr(ADDR_PASSES, 32'h3);
        rd_chk("passes", ADDR_PASSES, 32'h3);
        wr(8'h60, 32'hffff);
        rd_chk("stages after unmapped", ADDR_STAGES, 32'h5);
        $display("test limits done");

        // Start, then run stays up through the first 200 cycles of the on time of stage zero
        start(32'h1);
        out_chk(1'b1);
        held = 1'b1;
        repeat (200)
        begin
            @(posedge core_clk);
            #1;
            if (run !== 1'b1 || stage !== 3'h0)
                held = 1'b0;
        end
        chk("run held in on time", 32'h1, {31'h0, held});
        rd(ADDR_STATUS, rv);
        chk("status run and stage", 32'h2, rv & 32'h7a);
        stop();
        out_chk(1'b0);
        $display("test start stop done");

        // Restart with resume, then with hold
        start(32'h3);
        out_chk(1'b1);
        stop();
        chk("run after resume stop", 32'h0, {31'h0, run});
        start(32'h5);
        out_chk(1'b1);
        stop();
        out_chk(1'b0);
        $display("test resume hold done");

        // Two stages, two passes: exact stage 0 off and stage 1 on and off lengths, then finish without hold
        wr(ADDR_STAGES, 32'h2);
        wr(ADDR_PASSES, 32'h2);
        wr(ADDR_ON_BASE, 32'h2);
        wr(ADDR_OFF_BASE, 32'h1);
        wr(ADDR_ON_BASE + 8'h04, 32'h3);
        wr(ADDR_OFF_BASE + 8'h04, 32'h2);
        start(32'h1);
        out_chk(1'b1);
        for (int p = 0; p < 2; p++)
        begin
            wait_for(1'b0, "stage 0 on", 32'h0, 10, n);
            wait_for(1'b0, "stage 1 start", 32'h1, 10, n);
            chk("stage 0 off length", 32'(TICK), n);
            seq_chk(1'b1, 3'h1, 32'(p));
            wait_for(1'b0, "stage 1 on", 32'h0, 20, n);
            chk("stage 1 on length", 32'(3 * TICK), n);
            wait_for(1'b1, "pass done", 32'(p + 1), 20, n);
            chk("stage 1 off length", 32'(2 * TICK), n);
            seq_chk(p == 0, p == 0 ? 3'h0 : 3'h1, 32'(p + 1));
        end
        rd(ADDR_STATUS, rv);
        chk("status done", 32'h1c, rv);
        repeat (20) @(posedge core_clk);
        #1;
        seq_chk(1'b0, 3'h1, 32'h2);
        $display("test passes done");

        // Hold keeps run on at the last stage once all passes are done
        stop();
        start(32'h5);
        out_chk(1'b1);
        wait_for(1'b1, "hold passes", 32'h2, 100, n);
        seq_chk(1'b1, 3'h1, 32'h2);
        repeat (20) @(posedge core_clk);
        #1;
        seq_chk(1'b1, 3'h1, 32'h2);
        stop();
        seq_chk(1'b0, 3'h1, 32'h2);
        $display("test hold done");

        // Endless passes, then resume where stopped, then a fresh start
        wr(ADDR_PASSES, 32'h0);
        start(32'h1);
        wait_for(1'b1, "endless pass", 32'h1, 60, n);
        seq_chk(1'b1, 3'h0, 32'h1);
        wait_for(1'b0, "stage 0 on again", 32'h0, 20, n);
        chk("stage 0 on length", 32'(2 * TICK), n);
        wait_for(1'b0, "stage 1 again", 32'h1, 20, n);
        seq_chk(1'b1, 3'h1, 32'h1);
        stop();
        start(32'h3);
        seq_chk(1'b1, 3'h1, 32'h1);
        stop();
        start(32'h1);
        out_chk(1'b1);
        stop();
        $display("test endless resume done");
        test_done();
    end
endmodule
